// ===== design/sds_top.sv
`timescale 1ns/1ps
module sds_top #(
  parameter logic [31:0] IDENT_CYC =
    32'(sds_pkg::IDENT_MS * sds_pkg::CYC_PER_MS),
  parameter logic [31:0] VERSION_CYC =
    32'(sds_pkg::VERSION_MS * sds_pkg::CYC_PER_MS),
  parameter logic [31:0] STARTUP_CYC =
    32'(sds_pkg::STARTUP_MS * sds_pkg::CYC_PER_MS),
  parameter logic [31:0] ALT_CYC =
    32'(sds_pkg::ALT_MS * sds_pkg::CYC_PER_MS),
  parameter logic [47:0] THERM_LOW_CYC = 48'(sds_pkg::THERM_LOW_MIN *
    sds_pkg::MS_PER_MIN * sds_pkg::CYC_PER_MS),
  parameter logic [47:0] THERM_HIGH_CYC = 48'(sds_pkg::THERM_HIGH_MIN *
    sds_pkg::MS_PER_MIN * sds_pkg::CYC_PER_MS),
  // Arbitrary firmware version code
  parameter logic [19:0] FW_VERSION = 20'h0_0123,
  parameter int NFUNC = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [19:0] speedTenths,
  input wire logic calibFault,
  input wire logic internalFault,
  input wire logic defaultConfig,
  input wire logic tempAboveLow,
  input wire logic tempAboveHigh,
  input wire logic analogMismatch,
  input wire logic pulseFault,
  input wire logic [7:0] pulseDetail,
  input wire logic probeVoltFault,
  input wire logic relayUnsafe,
  input wire logic relayCheckFail,
  input wire logic biasFault,
  input wire logic tripActive,
  input wire logic [NFUNC-1:0] funcCond,
  output logic [3:0] dispMsg,
  output logic [19:0] dispValue,
  output logic dispFrac,
  output logic shutdown,
  output logic chanOkLed,
  output logic tripLed,
  output logic [NFUNC-1:0] funcLed,
  output logic [NFUNC-1:0] funcOut
);

  sds_pkg::sds_state_t state;
  sds_pkg::sds_state_t next_state;
  logic [31:0] seqCnt;
  logic [31:0] altCnt;
  logic [47:0] thermLowCnt;
  logic [47:0] thermHighCnt;
  logic [NFUNC-1:0] outMode;
  logic locateReq;
  logic [15:0] maxSpeed;
  logic thermalLatch;
  logic chcmpLatch;
  logic toothLatch;
  logic relayLatch;
  logic showMsg;
  logic [3:0] msgIdx;

  // Sequencer timing; counter restarts on each phase change and on reset
  wire logic [31:0] phaseLen = (state == sds_pkg::ST_IDENT) ? IDENT_CYC :
    (state == sds_pkg::ST_VERSION) ? VERSION_CYC : STARTUP_CYC;
  wire logic phaseDone = (state != sds_pkg::ST_RUN) &&
    (seqCnt == phaseLen - 32'h0000_0001);
  wire logic inRun = (state == sds_pkg::ST_RUN);
  wire logic startupEnd = (state == sds_pkg::ST_STARTUP) && phaseDone;

  always_comb
  begin
    next_state = state;
    case (state)
      sds_pkg::ST_IDENT: if (phaseDone) next_state = sds_pkg::ST_VERSION;
      sds_pkg::ST_VERSION: if (phaseDone) next_state = sds_pkg::ST_STARTUP;
      sds_pkg::ST_STARTUP: if (phaseDone) next_state = sds_pkg::ST_RUN;
      sds_pkg::ST_RUN: next_state = sds_pkg::ST_RUN;
      default: next_state = sds_pkg::ST_IDENT;
    endcase
  end

  // Phase register and phase cycle counter
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= sds_pkg::ST_IDENT;
      seqCnt <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      seqCnt <= (phaseDone || inRun) ? 32'h0000_0000 :
        seqCnt + 32'h0000_0001;
    end
  end

  // Heat timers count continuous time above each threshold
  wire logic thermTrip = (tempAboveLow &&
    thermLowCnt == THERM_LOW_CYC - 48'h0000_0000_0001) ||
    (tempAboveHigh && thermHighCnt == THERM_HIGH_CYC - 48'h0000_0000_0001);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      thermLowCnt <= 48'h0000_0000_0000;
      thermHighCnt <= 48'h0000_0000_0000;
    end
    else
    begin
      thermLowCnt <= tempAboveLow ?
        thermLowCnt + 48'h0000_0000_0001 : 48'h0000_0000_0000;
      thermHighCnt <= tempAboveHigh ?
        thermHighCnt + 48'h0000_0000_0001 : 48'h0000_0000_0000;
    end
  end

  // Switch-off faults latch until reset; a powered-off channel stays off
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      thermalLatch <= 1'b0;
      chcmpLatch <= 1'b0;
      toothLatch <= 1'b0;
      relayLatch <= 1'b0;
    end
    else
    begin
      thermalLatch <= thermalLatch || thermTrip;
      chcmpLatch <= chcmpLatch || (inRun && analogMismatch);
      toothLatch <= toothLatch || (inRun && pulseFault);
      relayLatch <= relayLatch || (startupEnd && relayUnsafe) ||
        (inRun && relayCheckFail);
    end
  end

  // Condition vector in fixed display order
  wire logic [sds_pkg::NCOND-1:0] cond = {
    biasFault,
    relayLatch,
    probeVoltFault,
    toothLatch,
    chcmpLatch,
    thermalLatch,
    speedTenths > sds_pkg::SPD_RANGE_MAX,
    defaultConfig,
    internalFault,
    calibFault,
    locateReq
  };
  wire logic anyCond = |cond;
  wire logic offState = thermalLatch || chcmpLatch || toothLatch;

  // Next active condition after the current one, wrapping around
  function automatic logic [3:0] sds_next_idx(
    input logic [sds_pkg::NCOND-1:0] mask,
    input logic [3:0] cur
  );
    logic [3:0] res;
    logic found;
    int k;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= sds_pkg::NCOND; i++)
    begin
      k = (int'(cur) + i) % sds_pkg::NCOND;
      if (!found && mask[k])
      begin
        res = 4'(k);
        found = 1'b1;
      end
    end
    return res;
  endfunction : sds_next_idx

  wire logic altWrap = (altCnt == ALT_CYC - 32'h0000_0001);
  wire logic [3:0] pickIdx = sds_next_idx(cond, msgIdx);

  // Alternation: speed slot, then next message slot, at a fixed period
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      altCnt <= 32'h0000_0000;
      showMsg <= 1'b0;
      msgIdx <= 4'(sds_pkg::NCOND - 1);
    end
    else if (!inRun || !anyCond)
    begin
      altCnt <= 32'h0000_0000;
      showMsg <= 1'b0;
    end
    else if (showMsg && !cond[msgIdx])
    begin
      showMsg <= 1'b0; // Message cleared: fall back to speed at once
      altCnt <= 32'h0000_0000;
    end
    else if (altWrap)
    begin
      altCnt <= 32'h0000_0000;
      showMsg <= !showMsg;
      if (!showMsg)
        msgIdx <= pickIdx;
    end
    else
      altCnt <= altCnt + 32'h0000_0001;
  end

  // Speed formatting: tenths kept only for slow machines and low speeds
  wire logic fracOk = (maxSpeed < sds_pkg::MAXSPD_FRAC_LIM) &&
    (speedTenths < sds_pkg::SPD_NOFRAC_MIN);
  wire logic [19:0] wholeRpm = speedTenths / 20'h0_000A;
  wire logic [19:0] speedShown = fracOk ? speedTenths : wholeRpm;

  // Display selection per phase
  wire logic [3:0] curMsg =
    (state == sds_pkg::ST_IDENT) ? sds_pkg::MSG_IDENT_TEXT :
    (state == sds_pkg::ST_VERSION) ? sds_pkg::MSG_VERSION :
    (state == sds_pkg::ST_STARTUP) ? sds_pkg::MSG_POWER_UP :
    showMsg ? sds_pkg::MSG_COND_BASE + msgIdx : sds_pkg::MSG_SPEED;
  wire logic [19:0] curValue =
    (state == sds_pkg::ST_VERSION) ? FW_VERSION :
    inRun ? speedShown : 20'h0_0000;

  // LED and output logic; LEDs held off until run and while off, outputs then at outMode level
  wire logic liveOut = inRun && !offState;
  wire logic [NFUNC-1:0] next_funcLed = liveOut ? funcCond : '0;
  wire logic next_chanOk = liveOut && !anyCond;
  wire logic next_trip = liveOut && tripActive;

  // Front outputs, all registered
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      dispMsg <= sds_pkg::MSG_IDENT_TEXT;
      dispValue <= 20'h0_0000;
      dispFrac <= 1'b0;
      shutdown <= 1'b0;
      chanOkLed <= 1'b0;
      tripLed <= 1'b0;
    end
    else
    begin
      dispMsg <= curMsg;
      dispValue <= curValue;
      dispFrac <= inRun && fracOk;
      shutdown <= offState;
      chanOkLed <= next_chanOk;
      tripLed <= next_trip;
    end
  end

  // One LED and one electrical output per function channel
  for (genvar g = 0; g < NFUNC; g++)
  begin : gFunc
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        funcLed[g] <= 1'b0;
        funcOut[g] <= 1'b0;
      end
      else
      begin
        funcLed[g] <= next_funcLed[g];
        funcOut[g] <= next_funcLed[g] ^ outMode[g];
      end
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  wire logic busReq = avs_read || avs_write;
  wire logic busDone = busReq && !avs_waitrequest;
  wire logic wrCtrl = busDone && avs_write && avs_address == sds_pkg::REG_CTRL;
  wire logic wrMax = busDone && avs_write && avs_address == sds_pkg::REG_MAXSPD;
  wire logic [31:0] statusWord = {17'h0_0000, offState,
    2'(state), 1'b0, cond};
  wire logic [31:0] rdMux =
    (avs_address == sds_pkg::REG_CTRL) ?
      {23'h00_0000, locateReq, 2'h0, outMode} :
    (avs_address == sds_pkg::REG_MAXSPD) ? {16'h0000, maxSpeed} :
    (avs_address == sds_pkg::REG_STATUS) ? statusWord :
    (avs_address == sds_pkg::REG_DETAIL) ? {24'h00_0000, pulseDetail} :
    32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      avs_readdata <= (busReq && avs_waitrequest) ? rdMux : avs_readdata;
    end
  end

  // Configuration registers; only the bus writes them
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      outMode <= sds_pkg::CTRL_MODE_RST;
      locateReq <= 1'b0;
      maxSpeed <= sds_pkg::MAXSPD_RST;
    end
    else
    begin
      if (wrCtrl && avs_byteenable[0])
        outMode <= avs_writedata[5:0];
      if (wrCtrl && avs_byteenable[1])
        locateReq <= avs_writedata[sds_pkg::CTRL_LOCATE_BIT];
      if (wrMax && avs_byteenable[0])
        maxSpeed[7:0] <= avs_writedata[7:0];
      if (wrMax && avs_byteenable[1])
        maxSpeed[15:8] <= avs_writedata[15:8];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_version_len: assert property (
    (state == sds_pkg::ST_VERSION) |-> (seqCnt < VERSION_CYC))
    else $error("Version phase overran its time");
  a_phase_order: assert property (
    (state != $past(state)) |-> (state == $past(state) + 2'b01))
    else $error("Power-up phases out of order");
  a_startup_hold: assert property (
    $past(state == sds_pkg::ST_STARTUP) |->
    (funcLed == '0 && !tripLed && !chanOkLed &&
     dispMsg == sds_pkg::MSG_POWER_UP))
    else $error("Outputs moved during power-up");
  a_frac_rule: assert property (
    dispFrac |-> ($past(maxSpeed) < sds_pkg::MAXSPD_FRAC_LIM))
    else $error("Fraction shown with high maximum speed");
  a_frac_high: assert property (
    dispFrac |-> (dispValue < sds_pkg::SPD_NOFRAC_MIN))
    else $error("Fraction shown at high speed");
  a_range_flag: assert property (
    (inRun && speedTenths > sds_pkg::SPD_RANGE_MAX) |=> !chanOkLed)
    else $error("Range condition missing");
  a_thermal_sticky: assert property (
    thermalLatch |=> (thermalLatch && shutdown))
    else $error("Thermal shutdown lost");
  a_out_level: assert property (
    funcOut == (funcLed ^ $past(outMode)))
    else $error("Output level does not follow mode");
  a_msg_between: assert property (
    ($past(inRun, 2) && $past(dispMsg) != sds_pkg::MSG_SPEED &&
     dispMsg != sds_pkg::MSG_SPEED) |-> (dispMsg == $past(dispMsg)))
    else $error("Two messages without speed between");
  a_bus_answer: assert property (
    (busReq && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not in one cycle");
  a_relay_end: assert property (
    (startupEnd && relayUnsafe) |=> ##1 cond[sds_pkg::C_TRIPSW])
    else $error("Relay fault at startup end not flagged");

  c_reach_run: cover property ($rose(inRun));
  c_msg_shown: cover property (showMsg && inRun);
  c_two_msgs: cover property ($fell(showMsg) ##[1:1000] $rose(showMsg));
  c_frac_shown: cover property (dispFrac);

endmodule : sds_top

// ===== design/sds_pkg.sv
package sds_pkg;
  // Clock and timing base
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam longint unsigned IDENT_MS = 1000;
  localparam longint unsigned VERSION_MS = 2000;
  localparam longint unsigned STARTUP_MS = 1000;
  localparam longint unsigned ALT_MS = 1000;
  localparam longint unsigned THERM_LOW_MIN = 120;
  localparam longint unsigned THERM_HIGH_MIN = 1;
  localparam longint unsigned MS_PER_MIN = 60_000;
  localparam int SEQ_W = 32;
  localparam int THERM_W = 48;

  // Speed limits, in tenths of rpm
  localparam int SPD_W = 20;
  localparam logic [19:0] SPD_RANGE_MAX = 20'h9_FFF6;
  localparam logic [19:0] SPD_NOFRAC_MIN = 20'h1_86A0;
  localparam logic [15:0] MAXSPD_FRAC_LIM = 16'h0064;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MAXSPD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_DETAIL = 4'hC;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOCATE_BIT = 8;
  localparam int STAT_PHASE_LSB = 12;
  localparam int STAT_SHUT_BIT = 14;
  localparam logic [5:0] CTRL_MODE_RST = 6'h00;
  localparam logic [15:0] MAXSPD_RST = 16'h0BB8;

  // Condition indices, in display order
  localparam int NCOND = 11;
  localparam int C_LOCATE = 0;
  localparam int C_CALIB = 1;
  localparam int C_INTERNAL = 2;
  localparam int C_DEFAULT = 3;
  localparam int C_RANGE = 4;
  localparam int C_THERMAL = 5;
  localparam int C_CHCMP = 6;
  localparam int C_TOOTH = 7;
  localparam int C_PROBE = 8;
  localparam int C_TRIPSW = 9;
  localparam int C_BIAS = 10;

  typedef enum logic [1:0] {
    ST_IDENT = 2'b00,
    ST_VERSION = 2'b01,
    ST_STARTUP = 2'b10,
    ST_RUN = 2'b11
  } sds_state_t;

  // Display content codes; condition messages start at MSG_COND_BASE
  localparam logic [3:0] MSG_SPEED = 4'h0;
  localparam logic [3:0] MSG_IDENT_TEXT = 4'h1;
  localparam logic [3:0] MSG_VERSION = 4'h2;
  localparam logic [3:0] MSG_POWER_UP = 4'h3;
  localparam logic [3:0] MSG_COND_BASE = 4'h4;
endpackage : sds_pkg

// ===== tb/sds_panel_model.sv
`timescale 1ns/1ps
// Operator panel: keeps a log of every change of the shown content
module sds_panel_model (
  input wire logic clk,
  input wire logic logClr,
  input wire logic [3:0] dispMsg
);
  logic [3:0] lastMsg;
  logic [3:0] msgLog[$];
  // A steady message is logged once, so the log shows alternation
  always @(posedge clk)
  begin
    if (logClr)
    begin
      msgLog.delete();
    end
    else if (dispMsg !== lastMsg)
    begin
      msgLog.push_back(dispMsg);
    end
    lastMsg <= dispMsg;
  end
endmodule : sds_panel_model

// ===== tb/sds_top_tb.sv
`timescale 1ns/1ps
module sds_top_tb;
  localparam int ALT = 10;
  localparam logic [31:0] PH_LEN = 32'h0000_0014; // Short power-up phases
  localparam logic [31:0] ALT_LEN = 32'h0000_000A;
  localparam logic [19:0] FW = 20'h0_0ABC; // Arbitrary version code
  logic clk, srst, avs_read, avs_write, avs_waitrequest, logClr;
  logic [3:0] avs_address, avs_byteenable, dispMsg;
  logic [31:0] avs_writedata, avs_readdata;
  logic [19:0] speedTenths, dispValue;
  logic calibFault, internalFault, defaultConfig, tempAboveLow;
  logic tempAboveHigh, analogMismatch, pulseFault, probeVoltFault;
  logic relayUnsafe, relayCheckFail, biasFault, tripActive;
  logic dispFrac, shutdown, chanOkLed, tripLed;
  logic [7:0] pulseDetail;
  logic [5:0] funcCond, funcLed, funcOut;
  int mismatches, cmp_count;
  // Speed display cases: max speed, speed, shown value, fraction flag
  logic [15:0] mx [4] = '{16'h0063, 16'h0063, 16'h0063, 16'h0064};
  logic [19:0] sp [4] = '{20'h0_01F4, 20'h1_86A0, 20'h1_869F, 20'h0_01F4};
  logic [19:0] vl [4] = '{20'h0_01F4, 20'h0_2710, 20'h1_869F, 20'h0_0032};
  logic fr [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  int cl [7] = '{0, 1, 2, 3, 4, 8, 10};

  // Short counts keep the run brief; expectations use the same values
  sds_top #(.IDENT_CYC(PH_LEN), .VERSION_CYC(PH_LEN),
    .STARTUP_CYC(PH_LEN), .ALT_CYC(ALT_LEN),
    .THERM_LOW_CYC(48'h0000_0000_0014), .THERM_HIGH_CYC(48'h0000_0000_000A),
    .FW_VERSION(FW)) u_dut (
    .clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .speedTenths,
    .calibFault, .internalFault, .defaultConfig, .tempAboveLow,
    .tempAboveHigh, .analogMismatch, .pulseFault, .pulseDetail,
    .probeVoltFault, .relayUnsafe, .relayCheckFail, .biasFault,
    .tripActive, .funcCond, .dispMsg, .dispValue, .dispFrac, .shutdown,
    .chanOkLed, .tripLed, .funcLed, .funcOut);
  sds_panel_model u_panel (.clk(clk), .logClr(logClr), .dispMsg(dispMsg));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_read <= !we;
    avs_write <= we;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge clk);
    end
    check("bus_answer", n < 100, 1'b1);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wait_msg(input logic [3:0] m);
    int n;
    n = 0;
    while (dispMsg !== m && n < 60)
    begin
      n++;
      @(posedge clk);
    end
    check("msg_seen", dispMsg, m);
  endtask : wait_msg

  task automatic drive(input int i, input logic v);
    logic [31:0] d;
    case (i)
      0: bus(1'b1, sds_pkg::REG_CTRL, {23'h0, v, 8'h00}, 4'h2, d);
      1: calibFault <= v;
      2: internalFault <= v;
      3: defaultConfig <= v;
      4: speedTenths <= v ? 20'hA_0000 : 20'h0_3039;
      8: probeVoltFault <= v;
      10: biasFault <= v;
      default: ;
    endcase
  endtask : drive

  // Each message must be the next active one, with speed shown between
  task automatic check_order(input logic [15:0] m);
    logic [3:0] p, e;
    int seen;
    p = 4'h0;
    seen = 0;
    foreach (u_panel.msgLog[k])
    begin
      if (u_panel.msgLog[k] != 4'h0)
      begin
        if (p != 4'h0)
        begin
          e = p + 4'h1;
          while (!m[e])
          begin
            e = e + 4'h1;
          end
          check("order", u_panel.msgLog[k], e);
          check("speed_gap", u_panel.msgLog[k-1], 4'h0);
          seen++;
        end
        p = u_panel.msgLog[k];
      end
    end
    check("order_count", seen >= 4, 1'b1);
  endtask : check_order

  task automatic clear_log();
    logClr <= 1'b1;
    @(posedge clk);
    logClr <= 1'b0;
  endtask : clear_log

  task automatic t_powerup();
    logic [31:0] d;
    repeat (10) @(posedge clk);
    check("ident", dispMsg, 4'h1);
    check("init_out", {funcOut, funcLed, tripLed, chanOkLed}, 14'h0000);
    repeat (20) @(posedge clk);
    check("version", dispMsg, 4'h2);
    check("fw_value", dispValue, FW);
    bus(1'b0, sds_pkg::REG_STATUS, 32'h0000_0000, 4'hF, d);
    check("phase_ver", d[13:12], 2'h1);
    // Switch-off fault and live conditions before run must be ignored
    analogMismatch <= 1'b1;
    funcCond <= 6'h3F;
    tripActive <= 1'b1;
    repeat (18) @(posedge clk);
    check("powerup", dispMsg, 4'h3);
    bus(1'b1, sds_pkg::REG_CTRL, 32'h0000_0001, 4'h1, d);
    repeat (3) @(posedge clk);
    check("deen_init", funcOut, 6'h01);
    check("hold_leds", {funcLed, tripLed, chanOkLed}, 8'h00);
    analogMismatch <= 1'b0;
    funcCond <= 6'h00;
    tripActive <= 1'b0;
    bus(1'b1, sds_pkg::REG_CTRL, 32'h0000_0000, 4'h1, d);
    repeat (20) @(posedge clk);
    check("run_speed", dispMsg, 4'h0);
    check("no_off", shutdown, 1'b0);
    check("speed_whole", dispValue, 20'h0_04D2);
    check("ok_led", chanOkLed, 1'b1);
  endtask : t_powerup

  task automatic t_regs();
    logic [31:0] d;
    bus(1'b0, sds_pkg::REG_MAXSPD, 32'h0000_0000, 4'hF, d);
    check("maxspd_rst", d, 32'h0000_0BB8);
    bus(1'b0, 4'h2, 32'h0000_0000, 4'hF, d);
    check("unmapped", d, 32'h0000_0000);
    bus(1'b1, sds_pkg::REG_STATUS, 32'hFFFF_FFFF, 4'hF, d);
    bus(1'b0, sds_pkg::REG_STATUS, 32'h0000_0000, 4'hF, d);
    check("status_ro", d, 32'h0000_3000);
    bus(1'b1, sds_pkg::REG_CTRL, 32'h0000_013F, 4'h1, d);
    bus(1'b0, sds_pkg::REG_CTRL, 32'h0000_0000, 4'hF, d);
    check("ctrl_lane", d, 32'h0000_003F);
    bus(1'b1, sds_pkg::REG_CTRL, 32'h0000_0000, 4'h3, d);
  endtask : t_regs

  task automatic t_frac();
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, sds_pkg::REG_MAXSPD, {16'h0000, mx[i]}, 4'h3, d);
      speedTenths <= sp[i];
      repeat (3) @(posedge clk);
      check("frac", dispFrac, fr[i]);
      check("value", dispValue, vl[i]);
    end
    bus(1'b1, sds_pkg::REG_MAXSPD, 32'h0000_0BB8, 4'h3, d);
    speedTenths <= 20'h0_3039;
  endtask : t_frac

  task automatic t_conds();
    logic [31:0] d;
    int n;
    foreach (cl[j])
    begin
      drive(cl[j], 1'b1);
      wait_msg(sds_pkg::MSG_COND_BASE + 4'(cl[j]));
      check("ok_off", chanOkLed, 1'b0);
      n = 0;
      while (dispMsg === 4'h5 && n < 40)
      begin
        n++;
        @(posedge clk);
      end
      if (cl[j] == 1)
      begin
        check("alt_len", n, ALT);
      end
      bus(1'b0, sds_pkg::REG_STATUS, 32'h0000_0000, 4'hF, d);
      check("stat_bit", d[cl[j]], 1'b1);
      drive(cl[j], 1'b0);
      // Clear seen one edge later, speed registered on the next
      repeat (3) @(posedge clk);
      check("msg_clear", dispMsg, 4'h0);
    end
  endtask : t_conds

  task automatic t_order();
    drive(0, 1'b1);
    drive(2, 1'b1);
    drive(10, 1'b1);
    clear_log();
    repeat (12 * ALT) @(posedge clk);
    check_order(16'h4050);
    drive(0, 1'b0);
    drive(2, 1'b0);
    drive(10, 1'b0);
  endtask : t_order

  task automatic t_leds();
    logic [31:0] d;
    funcCond <= 6'h2A;
    tripActive <= 1'b1;
    bus(1'b1, sds_pkg::REG_CTRL, 32'h0000_0030, 4'h1, d);
    repeat (3) @(posedge clk);
    check("func_led", funcLed, 6'h2A);
    check("func_out", funcOut, 6'h1A);
    check("trip_led", tripLed, 1'b1);
    check("ok_led", chanOkLed, 1'b1);
  endtask : t_leds

  task automatic t_latch();
    logic [31:0] d;
    tempAboveLow <= 1'b1;
    repeat (15) @(posedge clk);
    tempAboveLow <= 1'b0;
    repeat (2) @(posedge clk);
    check("low_short", shutdown, 1'b0);
    tempAboveHigh <= 1'b1;
    repeat (9) @(posedge clk);
    check("high_early", shutdown, 1'b0);
    repeat (5) @(posedge clk);
    tempAboveHigh <= 1'b0;
    check("high_off", shutdown, 1'b1);
    check("leds_held", {funcLed, tripLed}, 7'h00);
    analogMismatch <= 1'b1;
    pulseFault <= 1'b1;
    relayCheckFail <= 1'b1;
    pulseDetail <= 8'hA5;
    repeat (2) @(posedge clk);
    analogMismatch <= 1'b0;
    pulseFault <= 1'b0;
    relayCheckFail <= 1'b0;
    bus(1'b0, sds_pkg::REG_DETAIL, 32'h0000_0000, 4'hF, d);
    check("detail", d, 32'h0000_00A5);
    bus(1'b0, sds_pkg::REG_STATUS, 32'h0000_0000, 4'hF, d);
    check("latched", d, 32'h0000_72E0);
    clear_log();
    repeat (12 * ALT) @(posedge clk);
    check_order(16'h2E00);
  endtask : t_latch

  // Reset in mid-run restarts the sequence; relay unsafe at startup end
  task automatic t_relay();
    funcCond <= 6'h00;
    tripActive <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    relayUnsafe <= 1'b1;
    repeat (8) @(posedge clk);
    check("restart", dispMsg, 4'h1);
    check("unlatched", shutdown, 1'b0);
    repeat (60) @(posedge clk);
    relayUnsafe <= 1'b0;
    wait_msg(4'hD);
  endtask : t_relay

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  initial
  begin
    {avs_read, avs_write, logClr, calibFault, internalFault} = 5'h00;
    {defaultConfig, tempAboveLow, tempAboveHigh, analogMismatch} = 4'h0;
    {pulseFault, probeVoltFault, relayUnsafe, relayCheckFail} = 4'h0;
    {biasFault, tripActive} = 2'h0;
    avs_address = 4'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0000_0000;
    speedTenths = 20'h0_3039;
    pulseDetail = 8'h00;
    funcCond = 6'h00;
    mismatches = 0;
    cmp_count = 0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_powerup();
    t_regs();
    t_frac();
    t_conds();
    t_order();
    t_leds();
    t_latch();
    t_relay();
    close_out();
  end

  // Whole run needs under 2000 cycles; 20000 cycles means a hang
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule : sds_top_tb
